// *** verilog/cfm_top.sv ***
/*
  mask select and buffer pointer registers of the receive filters, with
  the masked identifier lookup that uses them; classic wishbone slave.
  assumes one clock, synchronous inputs, and filter and mask values
  supplied from the surrounding receive path.
*/
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "cfm_defines.svh"
module cfm_top
  import cfm_pkg::*;
#(
  parameter int ID_W = 29,
  parameter int ADR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [1:0] mode_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_valid_i,
  input wire logic [ID_W-1:0] rx_id_i,
  input wire logic [`CFM_N_FILT-1:0][ID_W-1:0] filter_id_i,
  input wire logic [ID_W-1:0] mask0_i,
  input wire logic [ID_W-1:0] mask1_i,
  output cfm_match_t match_o
);

  // whole state of the block except the pointer memory
  typedef struct packed {
    logic ack;                    // bus answer
    logic [3:0][7:0] msel;        // four mask select registers
    logic [7:0] rdat;             // read data of a select register
    logic rd_mem;                 // read data comes from pointer memory
    logic s1_v;                   // lookup stage one valid
    logic s1_any;                 // some filter hit
    logic [3:0] s1_idx;           // lowest hitting filter
    logic s2_v;                   // lookup stage two valid
    logic s2_any;
    logic [3:0] s2_idx;
  } st_t;

  st_t st_q; // registered state
  st_t st_d; // next state

  logic enh;                   // controller in an enhanced mode
  logic req;                   // bus request present
  cfm_reg_t dec;               // decoded bus address
  logic mem_we;                // pointer memory write
  logic [7:0] mem_ra;          // pointer word for the bus
  logic [7:0] mem_rb;          // pointer word for the lookup
  logic [`CFM_N_FILT-1:0] hit; // per-filter hit

  // map a byte address onto a register
  function automatic cfm_reg_t decode(input logic [ADR_W-1:0] a);
    cfm_reg_t r;
    r = '0;
    if (a == ADR_W'(`CFM_OFS_SEL0)) begin
      r.msel = 1'b1;
      r.idx = 3'h0;
    end else if (a == ADR_W'(`CFM_OFS_SEL1)) begin
      r.msel = 1'b1;
      r.idx = 3'h1;
    end else if (a == ADR_W'(`CFM_OFS_SEL2)) begin
      r.msel = 1'b1;
      r.idx = 3'h2;
    end else if (a == ADR_W'(`CFM_OFS_SEL3)) begin
      r.msel = 1'b1;
      r.idx = 3'h3;
    end else if (a >= ADR_W'(`CFM_OFS_BP_BASE) && a <= ADR_W'(`CFM_OFS_BP_LAST)
                 && a[1:0] == 2'b00) begin
      r.bp = 1'b1;
      r.idx = 3'((a - ADR_W'(`CFM_OFS_BP_BASE)) >> 2);
    end
    return r;
  endfunction

  // mask applied by one selector code
  function automatic logic [ID_W-1:0] pick_mask(input cfm_msel_t s,
                                                input logic [ID_W-1:0] m0,
                                                input logic [ID_W-1:0] m1,
                                                input logic [ID_W-1:0] f15);
    logic [ID_W-1:0] m;
    m = '1;
    case (s)
      CFM_MASK0: m = m0;
      CFM_MASK1: m = m1;
      CFM_FILT15: m = f15;
      default: m = '1;
    endcase
    return m;
  endfunction

  assign enh = (mode_i == `CFM_MODE_ENH1) || (mode_i == `CFM_MODE_ENH2);
  assign req = wb_cyc_i && wb_stb_i;
  assign dec = decode(wb_adr_i);

  // pointer write commits at the edge where the master sees ack
  assign mem_we = ce_i && req && st_q.ack && wb_we_i && wb_sel_i[0]
                  && dec.bp && enh;

  // per-filter masked compare
  always_comb begin
    cfm_msel_t s;
    logic [ID_W-1:0] m;
    s = CFM_MASK0;
    m = '1;
    hit = '0;
    for (int f = 0; f < `CFM_N_FILT; f++) begin
      // filter f sits in register f/4, field f%4, highest filter on top
      s = cfm_msel_t'(st_q.msel[f / `CFM_SELS_PER_REG]
          [(f % `CFM_SELS_PER_REG) * `CFM_SEL_W +: `CFM_SEL_W]);
      m = pick_mask(s, mask0_i, mask1_i, filter_id_i[`CFM_FILT_MASK_SRC]);
      hit[f] = (((rx_id_i ^ filter_id_i[f]) & m) == '0);
    end
  end

  // bus slave and lookup pipeline
  always_comb begin
    st_d = st_q;
    // answer one cycle after the request, drop the cycle after
    if (req && !st_q.ack) begin
      st_d.ack = 1'b1;
      st_d.rd_mem = dec.bp && enh;
      if (dec.msel && enh) begin
        st_d.rdat = st_q.msel[dec.idx[1:0]];
      end else begin
        st_d.rdat = 8'h00; // absent or unmapped reads zero
      end
    end else begin
      st_d.ack = 1'b0;
    end
    // select register write on the acknowledged edge
    if (req && st_q.ack && wb_we_i && wb_sel_i[0] && dec.msel && enh) begin
      st_d.msel[dec.idx[1:0]] = wb_dat_i[7:0];
    end
    // stage one: lowest hitting filter wins
    st_d.s1_v = rx_valid_i && enh;
    st_d.s1_any = |hit;
    st_d.s1_idx = 4'h0;
    for (int f = `CFM_N_FILT - 1; f >= 0; f--) begin
      if (hit[f]) begin
        st_d.s1_idx = 4'(f);
      end
    end
    // stage two: pointer word read in parallel
    st_d.s2_v = st_q.s1_v;
    st_d.s2_any = st_q.s1_any;
    st_d.s2_idx = st_q.s1_idx;
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.msel[0] <= `CFM_RST_SEL0;
      st_q.msel[1] <= `CFM_RST_SEL1;
      st_q.msel[2] <= `CFM_RST_SEL2;
      st_q.msel[3] <= `CFM_RST_SEL3;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // buffer pointer storage, two filters per word
  cfm_bp_mem #(
    .DEPTH(`CFM_BP_REGS),
    .W(8),
    .AW(3)
  ) i_cfm_bp_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .waddr_i(dec.idx),
    .wdata_i(wb_dat_i[7:0]),
    .raddr_a_i(dec.idx),
    .rdata_a_o(mem_ra),
    .raddr_b_i(st_q.s1_idx[3:1]),
    .rdata_b_o(mem_rb)
  );

  // bus outputs from registered sources
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = {24'h000000, st_q.rd_mem ? mem_ra : st_q.rdat};

  // lookup result and pointer decode
  always_comb begin
    logic [3:0] p;
    p = st_q.s2_idx[0] ? mem_rb[`CFM_BP_HI_POS +: `CFM_BP_W]
                       : mem_rb[`CFM_BP_LO_POS +: `CFM_BP_W];
    match_o.valid = st_q.s2_v;
    match_o.hit = st_q.s2_v && st_q.s2_any;
    match_o.filter = st_q.s2_idx;
    match_o.pointer = match_o.hit ? p : 4'h0;
    match_o.dest = CFM_DEST_NONE;
    match_o.buf_idx = 3'h0;
    if (match_o.hit) begin
      if (p == `CFM_BP_RX0 || p == `CFM_BP_RX1) begin
        match_o.dest = CFM_DEST_RX;
        match_o.buf_idx = 3'(p);
      end else if (p == `CFM_BP_PROG0) begin
        match_o.dest = CFM_DEST_PROG;
        match_o.buf_idx = 3'h0;
      end else if (p >= `CFM_BP_PROG1 && p <= `CFM_BP_PROG5) begin
        match_o.dest = CFM_DEST_PROG;
        match_o.buf_idx = 3'(p - `CFM_BP_PROG0);
      end else begin
        match_o.dest = CFM_DEST_RSVD;
      end
    end
  end

endmodule

// *** verilog/cfm_defines.svh ***
/*
  register offsets, reset values, field positions and codes of the
  filter mask select block.
  assumes it is included by its bare name, after nothing else.
*/
`ifndef CFM_DEFINES_SVH
`define CFM_DEFINES_SVH

// byte offsets of the four mask select registers
`define CFM_OFS_SEL0 8'h00
`define CFM_OFS_SEL1 8'h04
`define CFM_OFS_SEL2 8'h08
`define CFM_OFS_SEL3 8'h0c
// buffer pointer registers: eight words from this offset, two nibbles each
`define CFM_OFS_BP_BASE 8'h10
`define CFM_OFS_BP_LAST 8'h2c
`define CFM_BP_REGS 8

// reset values
`define CFM_RST_SEL0 8'h05
`define CFM_RST_SEL1 8'h05
`define CFM_RST_SEL2 8'h00
`define CFM_RST_SEL3 8'h00
`define CFM_RST_BP 8'h00

// field layout
`define CFM_SEL_W 2
`define CFM_SELS_PER_REG 4
`define CFM_BP_W 4
`define CFM_BP_LO_POS 0
`define CFM_BP_HI_POS 4
`define CFM_N_FILT 16
`define CFM_FILT_MASK_SRC 15

// controller operating modes
`define CFM_MODE_LEGACY 2'h0
`define CFM_MODE_ENH1 2'h1
`define CFM_MODE_ENH2 2'h2

// buffer pointer codes
`define CFM_BP_RX0 4'h0
`define CFM_BP_RX1 4'h1
`define CFM_BP_PROG0 4'h2
`define CFM_BP_PROG1 4'h3
`define CFM_BP_PROG5 4'h7

`endif

// *** verilog/cfm_pkg.sv ***
/*
  types of the filter mask select block.
  assumes the defines header is compiled alongside.
*/
package cfm_pkg;

  // mask chosen for one filter
  typedef enum logic [1:0] {
    CFM_MASK0 = 2'b00,
    CFM_MASK1 = 2'b01,
    CFM_FILT15 = 2'b10,
    CFM_NOMASK = 2'b11
  } cfm_msel_t;

  // kind of destination a buffer pointer names
  typedef enum logic [1:0] {
    CFM_DEST_RX = 2'b00,
    CFM_DEST_PROG = 2'b01,
    CFM_DEST_RSVD = 2'b10,
    CFM_DEST_NONE = 2'b11
  } cfm_dest_t;

  // result of one identifier lookup
  typedef struct packed {
    logic valid;
    logic hit;
    logic [3:0] filter;
    logic [3:0] pointer;
    cfm_dest_t dest;
    logic [2:0] buf_idx;
  } cfm_match_t;

  // decoded register address
  typedef struct packed {
    logic msel;
    logic bp;
    logic [2:0] idx;
  } cfm_reg_t;

endpackage

// *** verilog/cfm_bp_mem.sv ***
/*
  small memory for the buffer pointer registers: one write port and two
  registered read ports (bus side and lookup side).
  assumes a synchronous active-high reset and a clock enable.
*/
`timescale 1ns/10ps
`include "cfm_defines.svh"
module cfm_bp_mem #(
  parameter int DEPTH = `CFM_BP_REGS,
  parameter int W = 8,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_a_i,
  output logic [W-1:0] rdata_a_o,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [W-1:0] rdata_b_o
);

  // whole state of the memory
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] ra;
    logic [W-1:0] rb;
  } mem_st_t;

  mem_st_t st_q; // registered state
  mem_st_t st_d; // next state

  // write and both reads
  always_comb begin
    st_d = st_q;
    if (we_i) begin
      st_d.mem[waddr_i] = wdata_i;
    end
    st_d.ra = st_q.mem[raddr_a_i];
    st_d.rb = st_q.mem[raddr_b_i];
  end

  // reset clears every word, clock enable freezes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        st_q.mem[i] <= W'(`CFM_RST_BP);
      end
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  assign rdata_a_o = st_q.ra;
  assign rdata_b_o = st_q.rb;

endmodule

// *** tb/cfm_top_props.sv ***
/*
  checker of the filter mask select block.
  assumes it is bound to cfm_top and sees its ports only.
*/
`timescale 1ns/10ps
module cfm_top_props
  import cfm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [1:0] mode_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_valid_i,
  input cfm_match_t match_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // controller is in an enhanced mode
  logic enh;
  assign enh = (mode_i == 2'h1) || (mode_i == 2'h2);
  ack_one_cycle_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i ##1 ce_i |-> wb_ack_o)
    else $error("ack late");
  ack_single_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack too long");
  legacy_read_zero_a: assert property (
    wb_ack_o && !$past(enh) && !enh |-> wb_dat_o == 32'h0)
    else $error("legacy read not zero");
  lookup_answer_a: assert property (
    rx_valid_i && enh && ce_i ##1 ce_i[*2] |-> match_o.valid)
    else $error("lookup result missing");
  // a low clock enable must leave every output where it was
  freeze_hold_a: assert property (
    !ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o) && $stable(match_o))
    else $error("state moved while frozen");
  legacy_lookup_a: assert property (rx_valid_i && !enh |-> ##2 !match_o.valid)
    else $error("legacy lookup answered");
  valid_cause_a: assert property (
    match_o.valid && $past(ce_i) && $past(ce_i, 2) |-> $past(rx_valid_i, 2))
    else $error("result without request");
  rx_dest_a: assert property (
    match_o.valid && match_o.hit && match_o.pointer < 4'h2
    |-> match_o.dest == CFM_DEST_RX && match_o.buf_idx == match_o.pointer[2:0])
    else $error("receive buffer decode");
  prog_dest_a: assert property (
    match_o.valid && match_o.hit && match_o.pointer inside {[4'h2:4'h7]}
    |-> match_o.dest == CFM_DEST_PROG && match_o.buf_idx == 3'(match_o.pointer - 4'h2))
    else $error("programmable buffer decode");
  rsvd_dest_a: assert property (
    match_o.valid && match_o.hit && match_o.pointer[3] |-> match_o.dest == CFM_DEST_RSVD)
    else $error("reserved pointer decode");
endmodule
bind cfm_top cfm_top_props i_cfm_top_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .mode_i(mode_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .match_o(match_o));

// *** tb/testbench.sv ***
/*
  self-checking bench of the filter mask select block.
  assumes cfm_top with default widths and the checker bound to it.
*/
`timescale 1ns/10ps
module testbench
  import cfm_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1; // clock enable, dropped once to check freezing
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic [1:0] mode_i = 2'h1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [28:0] rx_id_i = 29'h0;
  logic [28:0] mask0_i = 29'h00000ff;
  logic [28:0] mask1_i = 29'h1ffff00;
  logic [15:0][28:0] filter_id_i;
  cfm_match_t match_o;
  logic [3:0][7:0] selb; // selector bytes last written
  logic [31:0] rd; // data of the last read
  int error_cnt = 0;
  int comparisons = 0;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  cfm_top i_cfm_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mode_i(mode_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i), .filter_id_i(filter_id_i),
    .mask0_i(mask0_i), .mask1_i(mask1_i), .match_o(match_o));
  // prints counts and verdict, ends the run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // compares register data
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // compares lookup results
  task automatic chk_match(input cfm_match_t got, input cfm_match_t exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, waits for ack; only the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    wb_sel_i <= 4'h1;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // expected lookup: lowest filter whose selected mask matches, pointer nibble f
  function automatic cfm_match_t expect_of(input logic [28:0] id);
    cfm_match_t e;
    logic [28:0] m;
    logic [1:0] s;
    e = '0;
    e.valid = 1'b1;
    e.dest = CFM_DEST_NONE;
    for (int f = 15; f >= 0; f--) begin
      s = selb[f/4][2*(f%4) +: 2];
      m = (s == 2'b00) ? mask0_i : (s == 2'b01) ? mask1_i : (s == 2'b10) ? filter_id_i[15] : '1;
      if (((id ^ filter_id_i[f]) & m) == '0) begin
        e.hit = 1'b1;
        e.filter = 4'(f);
      end
    end
    if (e.hit) begin
      e.pointer = e.filter;
      e.dest = e.pointer < 2 ? CFM_DEST_RX : e.pointer < 8 ? CFM_DEST_PROG : CFM_DEST_RSVD;
      e.buf_idx = e.pointer < 2 ? e.pointer[2:0] : e.pointer < 8 ? 3'(e.pointer - 2) : 3'h0;
    end
    return e;
  endfunction
  // one lookup; result stands in the cycle two after the taking edge and is
  // read at the edge that closes that cycle, before it is replaced
  task automatic lookup(input logic [28:0] id, input logic legacy);
    cfm_match_t g;
    @(posedge clk_i);
    rx_valid_i <= 1'b1;
    rx_id_i <= id;
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    g = match_o;
    if (legacy) chk_reg(32'(g.valid), 32'h0);
    else begin
      chk_match(g, expect_of(id));
    end
  endtask
  // main sequence
  initial begin
    for (int f = 0; f < 16; f++) filter_id_i[f] = 29'(f) * 29'h1111111;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    selb = {8'h00, 8'h00, 8'h05, 8'h05};
    for (int r = 0; r < 4; r++) begin
      wb(1'b0, 8'(4 * r), 8'h00);
      chk_reg(rd, {24'h0, selb[r]});
    end
    $display("test reset values done");
    for (int n = 0; n < 8; n++) begin
      wb(1'b1, 8'(16 + 4 * n), {4'(2 * n + 1), 4'(2 * n)});
      wb(1'b0, 8'(16 + 4 * n), 8'h00);
      chk_reg(rd, {24'h0, 4'(2 * n + 1), 4'(2 * n)});
    end
    $display("test pointers done");
    for (int p = 0; p < 4; p++) begin
      mode_i <= (p == 3) ? 2'h2 : 2'h1;
      for (int f = 0; f < 16; f++) selb[f/4][2*(f%4) +: 2] = 2'(f + p);
      for (int r = 0; r < 4; r++) begin
        wb(1'b1, 8'(4 * r), selb[r]);
        wb(1'b0, 8'(4 * r), 8'h00);
        chk_reg(rd, {24'h0, selb[r]});
      end
      for (int k = 0; k < 16; k++) begin
        lookup(filter_id_i[k] ^ 29'h0000001, 1'b0);
        lookup(filter_id_i[k] ^ 29'h1000000, 1'b0);
      end
      $display("test selector pass %0d done", p);
    end
    mode_i <= 2'h0;
    wb(1'b1, 8'h0c, 8'hff);
    wb(1'b0, 8'h0c, 8'h00);
    chk_reg(rd, 32'h0);
    lookup(filter_id_i[3], 1'b1);
    mode_i <= 2'h3;
    wb(1'b1, 8'h00, 8'hff);
    wb(1'b0, 8'h00, 8'h00);
    chk_reg(rd, 32'h0);
    lookup(filter_id_i[5], 1'b1);
    mode_i <= 2'h1;
    ce_i <= 1'b0;
    lookup(filter_id_i[3], 1'b1);
    ce_i <= 1'b1;
    wb(1'b0, 8'h0c, 8'h00);
    chk_reg(rd, {24'h0, selb[3]});
    wb(1'b0, 8'h00, 8'h00);
    chk_reg(rd, {24'h0, selb[0]});
    wb(1'b1, 8'h30, 8'hff);
    wb(1'b0, 8'h30, 8'h00);
    chk_reg(rd, 32'h0);
    $display("test legacy and unmapped done");
    report_and_stop();
  end
  // watchdog: about fourteen times the expected run
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule
